// [rtl/storage_dev_port.sv]
// Purpose: Device end of the host address, parity and strobe port.
// Assumes: One clock, the host bus clock; straps steady after reset.
// Notes: Master cycles are requested on the user side, one word each.
// Function
// - Low parity lines cover bytes zero to two.
// - Top parity line covers byte three.
// - Parity valid on low lanes always; top lane only with parity-through on.
// - Control bit two disables parity-through.
// - Without parity-through, top pin is abort input.
// - Abort finishes current transfer, then releases bus.
// - Mode one master drives data strobe.
// - Modes two to four latch read data.
// - Unused latch enable is held high.
// - Upper address input as slave, output as master.
// - Modes one to three: low pins are address.
// - Mode four: low pins are byte enables.
// - Mode one address strobe marks valid address.
// - Mode two transfer start marks cycle start.
// - Modes three, four address status marks cycle.
// - Host picks bus mode by strap pins.
// - All host activity timed by host clock.
`include "host_port_regs.svh"
module storage_dev_port (
  input wire logic i_clock,
  input wire logic i_rst,
  host_port_if.device bus,
  input wire logic [7:0] i_ctrl_zero,
  input wire logic i_req,
  input wire logic i_write,
  input wire host_port_pkg::word_t i_addr,
  input wire host_port_pkg::word_t i_wdata,
  input wire host_port_pkg::lanes_t i_lanes,
  output logic o_busy,
  output logic o_done,
  output logic o_aborted,
  output host_port_pkg::word_t o_rdata,
  output host_port_pkg::word_t o_slave_addr,
  output logic o_slave_start,
  output logic o_parity_err,
  output logic o_bus_released
);
  import host_port_pkg::*;

  typedef enum logic [1:0] {st_idle, st_start, st_data, st_release} dev_state_t;
  dev_state_t state_r;
  bus_mode_t mode_r;
  logic [2:0] strap_s1_r, strap_s2_r;
  logic abort_s1_r, abort_s2_r, abort_pend_r;
  logic ack_s1_r, ack_s2_r, latch_en_s1_r, latch_en_s2_r, start_s1_r, start_s2_r;
  word_t data_s1_r, data_s2_r, addr_s1_r, addr_s2_r;
  logic [3:0] par_s1_r, par_s2_r;
  logic write_r;
  word_t addr_r, wdata_r;
  lanes_t lanes_r;
  logic through_off;
  word_t latch_r;
  logic [3:0] rd_par;
  function automatic logic [3:0] lane_parity(input word_t d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++)
      p[i] = ~^d[8*i +: 8];
    return p;
  endfunction
  assign through_off = i_ctrl_zero[`PARITY_THROUGH_OFF_BIT];
  assign rd_par = lane_parity(data_s2_r);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      abort_s1_r <= 1'b1;
      abort_s2_r <= 1'b1;
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      latch_en_s1_r <= 1'b1;
      latch_en_s2_r <= 1'b1;
      start_s1_r <= 1'b1;
      start_s2_r <= 1'b1;
      data_s1_r <= '0;
      data_s2_r <= '0;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      par_s1_r <= '0;
      par_s2_r <= '0;
    end
    else
    begin
      strap_s1_r <= bus.bus_select_straps;
      strap_s2_r <= strap_s1_r;
      abort_s1_r <= bus.host_parity_o[3];
      abort_s2_r <= abort_s1_r;
      ack_s1_r <= bus.cycle_ack_n;
      ack_s2_r <= ack_s1_r;
      latch_en_s1_r <= bus.read_latch_enable;
      latch_en_s2_r <= latch_en_s1_r;
      start_s1_r <= bus.host_start_n_o;
      start_s2_r <= start_s1_r;
      data_s1_r <= bus.host_data_o;
      data_s2_r <= data_s1_r;
      addr_s1_r <= bus.host_addr_o;
      addr_s2_r <= addr_s1_r;
      par_s1_r <= bus.host_parity_o;
      par_s2_r <= par_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      mode_r <= mode_1;
    else
    begin
      case (strap_s2_r)
        `STRAP_MODE1: mode_r <= mode_1;
        `STRAP_MODE2: mode_r <= mode_2;
        `STRAP_MODE3: mode_r <= mode_3;
        default: mode_r <= mode_4;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      abort_pend_r <= 1'b0;
    else if (through_off && !abort_s2_r)
      abort_pend_r <= 1'b1;
    else if (state_r == st_release || state_r == st_idle)
      abort_pend_r <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= st_idle;
      write_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      lanes_r <= '0;
      o_done <= 1'b0;
      o_aborted <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      o_aborted <= 1'b0;
      case (state_r)
        st_idle:
        begin
          if (i_req && !abort_pend_r)
          begin
            state_r <= st_start;
            write_r <= i_write;
            addr_r <= i_addr;
            wdata_r <= i_wdata;
            lanes_r <= i_lanes;
          end
        end
        st_start: state_r <= st_data;
        st_data:
        begin
          if (!ack_s2_r)
          begin
            o_done <= 1'b1;
            state_r <= abort_pend_r ? st_release : st_idle;
          end
        end
        st_release:
        begin
          o_aborted <= 1'b1;
          state_r <= st_idle;
        end
        default: state_r <= st_idle;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      bus.dev_addr_o <= '0;
      bus.dev_addr_oe_n <= '1;
      bus.dev_start_n_o <= 1'b1;
      bus.dev_start_oe_n <= 1'b1;
      bus.data_strobe_n <= 1'b1;
      bus.data_strobe_oe_n <= 1'b1;
      bus.dev_data_o <= '0;
      bus.dev_data_oe_n <= 1'b1;
      bus.dev_parity_o <= '0;
      bus.dev_parity_oe_n <= '1;
      o_busy <= 1'b0;
      o_bus_released <= 1'b1;
    end
    else
    begin
      o_busy <= (state_r != st_idle);
      o_bus_released <= (state_r == st_idle) || (state_r == st_release);
      if (state_r == st_start || state_r == st_data)
      begin
        bus.dev_addr_oe_n <= '0;
        if (mode_r == mode_4)
        begin
          bus.dev_addr_o <= {addr_r[31:2], ~lanes_r[1], ~lanes_r[0]};
        end
        else
        begin
          bus.dev_addr_o <= addr_r;
        end
        bus.dev_start_oe_n <= 1'b0;
        bus.dev_start_n_o <= !(state_r == st_start);
        bus.data_strobe_oe_n <= (mode_r != mode_1);
        bus.data_strobe_n <= !(mode_r == mode_1 && state_r == st_data);
        bus.dev_data_oe_n <= !write_r;
        bus.dev_data_o <= wdata_r;
        bus.dev_parity_o <= lane_parity(wdata_r);
        bus.dev_parity_oe_n <= {through_off | !write_r, {3{!write_r}}};
      end
      else
      begin
        bus.dev_addr_oe_n <= '1;
        bus.dev_start_oe_n <= 1'b1;
        bus.dev_start_n_o <= 1'b1;
        bus.data_strobe_oe_n <= 1'b1;
        bus.data_strobe_n <= 1'b1;
        bus.dev_data_oe_n <= 1'b1;
        bus.dev_parity_oe_n <= '1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      latch_r <= '0;
      o_rdata <= '0;
      o_slave_addr <= '0;
      o_slave_start <= 1'b0;
      o_parity_err <= 1'b0;
    end
    else
    begin
      if (mode_r == mode_1 || latch_en_s2_r)
      begin
        latch_r <= data_s2_r;
      end
      if (state_r == st_data && !ack_s2_r && !write_r)
      begin
        o_rdata <= (mode_r == mode_1) ? data_s2_r : latch_r;
        o_parity_err <= (par_s2_r[2:0] != rd_par[2:0]) ||
                        (!through_off && par_s2_r[3] != rd_par[3]);
      end
      o_slave_start <= (state_r == st_idle) && !start_s2_r;
      if ((state_r == st_idle) && !start_s2_r)
      begin
        o_slave_addr <= addr_s2_r;
      end
    end
  end
endmodule

// [inc/host_port_regs.svh]
// Purpose: Constants shared by both ends of the host address and data port.
// Assumes: Included by bare name; definitions only.
// Notes: Bus mode codes follow the strap encoding used by both ends.
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define PARITY_THROUGH_OFF_BIT 2
`define CTRL_ZERO_RESET 8'h00
`define STRAP_MODE1 3'h0
`define STRAP_MODE2 3'h1
`define STRAP_MODE3 3'h2
`define STRAP_MODE4 3'h3
`define XFER_WAIT_CYCLES 4'h2
`endif

// [inc/host_port_pkg.sv]
// Purpose: Types shared by both ends of the host address and data port.
// Assumes: Nothing.
// Notes: Bus mode is decoded from the strap pins.
package host_port_pkg;
  typedef enum logic [1:0] {mode_1, mode_2, mode_3, mode_4} bus_mode_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0] lanes_t;
endpackage

// [inc/host_port_if.sv]
// Purpose: Pin bundle between the storage processor and the host system.
// Assumes: Output enables are low while a party drives a pin.
// Notes: Each end samples the other end's output signals directly; the bench resolves no wire levels.
interface host_port_if;
  logic [31:0] dev_addr_o;
  logic [31:0] dev_addr_oe_n;
  logic [31:0] host_addr_o;
  logic [31:0] host_addr_oe_n;
  logic [31:0] dev_data_o;
  logic dev_data_oe_n;
  logic [31:0] host_data_o;
  logic host_data_oe_n;
  logic [3:0] dev_parity_o;
  logic [3:0] dev_parity_oe_n;
  logic [3:0] host_parity_o;
  logic [3:0] host_parity_oe_n;
  logic dev_start_n_o;
  logic dev_start_oe_n;
  logic host_start_n_o;
  logic host_start_oe_n;
  logic data_strobe_n;
  logic data_strobe_oe_n;
  logic read_latch_enable;
  logic cycle_ack_n;
  logic [2:0] bus_select_straps;
  modport device (
    output dev_addr_o, dev_addr_oe_n, dev_data_o, dev_data_oe_n,
    output dev_parity_o, dev_parity_oe_n, dev_start_n_o, dev_start_oe_n,
    output data_strobe_n, data_strobe_oe_n,
    input host_addr_o, host_addr_oe_n, host_data_o, host_data_oe_n,
    input host_parity_o, host_parity_oe_n, host_start_n_o, host_start_oe_n,
    input read_latch_enable, cycle_ack_n, bus_select_straps
  );
  modport host (
    output host_addr_o, host_addr_oe_n, host_data_o, host_data_oe_n,
    output host_parity_o, host_parity_oe_n, host_start_n_o, host_start_oe_n,
    output read_latch_enable, cycle_ack_n, bus_select_straps,
    input dev_addr_o, dev_addr_oe_n, dev_data_o, dev_data_oe_n,
    input dev_parity_o, dev_parity_oe_n, dev_start_n_o, dev_start_oe_n,
    input data_strobe_n, data_strobe_oe_n
  );
endinterface

// [rtl/host_sys_port.sv]
// Purpose: Host end of the address, parity and strobe port.
// Assumes: One clock; the host acknowledges each device master cycle.
// Notes: Issues slave accesses on user request.
`include "host_port_regs.svh"
module host_sys_port (
  input wire logic i_clock,
  input wire logic i_rst,
  host_port_if.host bus,
  input wire logic [2:0] i_mode_straps,
  input wire logic i_abort,
  input wire logic i_through_off,
  input wire logic i_slave_req,
  input wire host_port_pkg::word_t i_slave_addr,
  input wire host_port_pkg::word_t i_read_data,
  output host_port_pkg::word_t o_master_addr,
  output host_port_pkg::word_t o_master_wdata,
  output logic o_master_cycle,
  output logic o_parity_err
);
  import host_port_pkg::*;

  typedef enum logic [1:0] {hs_idle, hs_wait, hs_ack, hs_slave} host_state_t;
  host_state_t state_r;
  logic [3:0] wait_r;
  logic start_s1_r, start_s2_r;
  word_t addr_s1_r, addr_s2_r, data_s1_r, data_s2_r;
  logic [3:0] par_s1_r, par_s2_r;
  logic [3:0] rd_par, wr_par;

  function automatic logic [3:0] lane_parity(input word_t d);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++)
    begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction
  assign rd_par = lane_parity(i_read_data);
  assign wr_par = lane_parity(data_s2_r);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for device-driven pins.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_s1_r <= 1'b1;
      start_s2_r <= 1'b1;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      data_s1_r <= '0;
      data_s2_r <= '0;
      par_s1_r <= '0;
      par_s2_r <= '0;
    end
    else
    begin
      start_s1_r <= bus.dev_start_n_o | bus.dev_start_oe_n;
      start_s2_r <= start_s1_r;
      addr_s1_r <= bus.dev_addr_o;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= bus.dev_data_o;
      data_s2_r <= data_s1_r;
      par_s1_r <= bus.dev_parity_o;
      par_s2_r <= par_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle handling and pin drive.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= hs_idle;
      wait_r <= '0;
      bus.bus_select_straps <= `STRAP_MODE1;
      bus.read_latch_enable <= 1'b1;
      bus.cycle_ack_n <= 1'b1;
      bus.host_addr_o <= '0;
      bus.host_addr_oe_n <= '1;
      bus.host_data_o <= '0;
      bus.host_data_oe_n <= 1'b1;
      bus.host_parity_o <= 4'hF;
      bus.host_parity_oe_n <= '1;
      bus.host_start_n_o <= 1'b1;
      bus.host_start_oe_n <= 1'b1;
      o_master_addr <= '0;
      o_master_wdata <= '0;
      o_master_cycle <= 1'b0;
      o_parity_err <= 1'b0;
    end
    else
    begin
      bus.bus_select_straps <= i_mode_straps;
      bus.read_latch_enable <= 1'b1;
      bus.host_data_o <= i_read_data;
      bus.host_parity_o <= {i_through_off ? !i_abort : rd_par[3], rd_par[2:0]};
      bus.host_parity_oe_n <= '0;
      bus.host_data_oe_n <= 1'b0;
      bus.cycle_ack_n <= 1'b1;
      bus.host_start_n_o <= 1'b1;
      bus.host_start_oe_n <= 1'b1;
      bus.host_addr_oe_n <= '1;
      o_master_cycle <= 1'b0;
      case (state_r)
        hs_idle:
        begin
          if (!start_s2_r)
          begin
            o_master_addr <= addr_s2_r;
            wait_r <= `XFER_WAIT_CYCLES;
            state_r <= hs_wait;
          end
          else if (i_slave_req)
          begin
            bus.host_addr_o <= i_slave_addr;
            bus.host_addr_oe_n <= '0;
            bus.host_start_n_o <= 1'b0;
            bus.host_start_oe_n <= 1'b0;
            state_r <= hs_slave;
          end
        end
        hs_wait:
        begin
          if (wait_r == 4'h0)
          begin
            bus.cycle_ack_n <= 1'b0;
            state_r <= hs_ack;
          end
          else
          begin
            wait_r <= wait_r - 4'h1;
          end
        end
        hs_ack:
        begin
          o_master_wdata <= data_s2_r;
          o_master_cycle <= 1'b1;
          o_parity_err <= (par_s2_r[2:0] != wr_par[2:0]) ||
                          (!i_through_off && par_s2_r[3] != wr_par[3]);
          state_r <= hs_idle;
        end
        hs_slave: state_r <= hs_idle;
        default: state_r <= hs_idle;
      endcase
    end
  end
endmodule

// [sim/host_port_asserts.sv]
// Purpose: Concurrent checks on the pins between the two port ends.
// Assumes: One clock; straps change only while reset is held.
// Notes: Instantiated by tb beside the pin bundle.
module host_port_asserts (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_ctrl_zero,
  input wire logic [31:0] dev_addr_oe_n,
  input wire logic [31:0] dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic [3:0] dev_parity_o,
  input wire logic [3:0] dev_parity_oe_n,
  input wire logic [3:0] host_parity_o,
  input wire logic [3:0] host_parity_oe_n,
  input wire logic dev_start_n_o,
  input wire logic dev_start_oe_n,
  input wire logic host_start_oe_n,
  input wire logic data_strobe_n,
  input wire logic data_strobe_oe_n,
  input wire logic [2:0] bus_select_straps
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(dev_start_n_o) && !dev_start_oe_n;
  endsequence
  sequence s_strobe;
    ##[1:3] (!data_strobe_n && !data_strobe_oe_n);
  endsequence
  sequence s_abort;
    i_ctrl_zero[2] && !host_parity_oe_n[3] && !host_parity_o[3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  property p_par_low;
    !dev_data_oe_n |-> (dev_parity_oe_n[2:0] == 3'h0) && (dev_parity_o[2:0] ==
      {~^dev_data_o[23:16], ~^dev_data_o[15:8], ~^dev_data_o[7:0]});
  endproperty
  property p_par_top;
    !dev_data_oe_n && !i_ctrl_zero[2] |->
      !dev_parity_oe_n[3] && (dev_parity_o[3] == ~^dev_data_o[31:24]);
  endproperty
  property p_top_off;
    i_ctrl_zero[2] && !dev_data_oe_n |-> dev_parity_oe_n[3];
  endproperty
  property p_strobe_mode;
    bus_select_straps != 3'h0 |-> data_strobe_oe_n;
  endproperty
  property p_strobe_follow;
    (bus_select_straps == 3'h0) ##0 s_start |-> s_strobe;
  endproperty
  property p_addr_start;
    !dev_start_oe_n && !dev_start_n_o |-> dev_addr_oe_n[31:2] == 30'h0000_0000;
  endproperty
  property p_slave_quiet;
    !host_start_oe_n |-> (&dev_addr_oe_n) && dev_start_oe_n;
  endproperty
  property p_abort_rel;
    s_abort |-> ##[0:40] (&dev_addr_oe_n);
  endproperty
  property p_abort_hold;
    s_abort [*6] |-> dev_start_oe_n || dev_start_n_o;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_par_low: assert property (p_par_low)
    else $error("low parity lines wrong");
  a_par_top: assert property (p_par_top)
    else $error("top parity line wrong");
  a_top_off: assert property (p_top_off)
    else $error("top pin driven with parity-through off");
  a_strobe_mode: assert property (p_strobe_mode)
    else $error("data strobe driven outside mode one");
  a_strobe_follow: assert property (p_strobe_follow)
    else $error("data strobe missing after cycle start");
  a_addr_start: assert property (p_addr_start)
    else $error("address not driven with cycle start");
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("device drives address in slave access");
  a_abort_rel: assert property (p_abort_rel)
    else $error("bus not released after abort");
  a_abort_hold: assert property (p_abort_hold)
    else $error("new cycle started while abort held");
endmodule

// [sim/tb.sv]
// Purpose: Self-checking bench joining both port ends through the pin bundle.
// Assumes: Straps change only while reset is held.
// Notes: Each bus mode runs a master write, a master read and a slave access.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import host_port_pkg::*;
  logic i_clock;
  logic i_rst;
  logic [7:0] ctrl;
  logic req;
  logic wr;
  logic abort;
  logic sreq;
  logic [2:0] straps;
  word_t addr;
  word_t wdata;
  word_t saddr;
  word_t rdata_in;
  word_t rdata;
  word_t slave_addr;
  word_t maddr;
  word_t mwdata;
  word_t pin_addr;
  lanes_t lanes;
  logic busy;
  logic done;
  logic aborted;
  logic slave_start;
  logic dperr;
  logic hperr;
  logic released;
  logic mcycle;
  int err_count = 0;
  int check_count = 0;
  int done_cnt = 0;
  int abort_cnt = 0;
  int slave_cnt = 0;
  int mcyc_cnt = 0;
  host_port_if host_bus();
  storage_dev_port u_storage_dev_port (.i_clock(i_clock), .i_rst(i_rst), .bus(host_bus),
    .i_ctrl_zero(ctrl), .i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata),
    .i_lanes(lanes), .o_busy(busy), .o_done(done), .o_aborted(aborted), .o_rdata(rdata),
    .o_slave_addr(slave_addr), .o_slave_start(slave_start), .o_parity_err(dperr),
    .o_bus_released(released));
  host_sys_port u_host_sys_port (.i_clock(i_clock), .i_rst(i_rst), .bus(host_bus),
    .i_mode_straps(straps), .i_abort(abort), .i_through_off(ctrl[2]), .i_slave_req(sreq),
    .i_slave_addr(saddr), .i_read_data(rdata_in), .o_master_addr(maddr),
    .o_master_wdata(mwdata), .o_master_cycle(mcycle), .o_parity_err(hperr));
  host_port_asserts u_host_port_asserts (.i_clock(i_clock), .i_rst(i_rst),
    .i_ctrl_zero(ctrl), .dev_addr_oe_n(host_bus.dev_addr_oe_n),
    .dev_data_o(host_bus.dev_data_o), .dev_data_oe_n(host_bus.dev_data_oe_n),
    .dev_parity_o(host_bus.dev_parity_o), .dev_parity_oe_n(host_bus.dev_parity_oe_n),
    .host_parity_o(host_bus.host_parity_o), .host_parity_oe_n(host_bus.host_parity_oe_n),
    .dev_start_n_o(host_bus.dev_start_n_o), .dev_start_oe_n(host_bus.dev_start_oe_n),
    .host_start_oe_n(host_bus.host_start_oe_n), .data_strobe_n(host_bus.data_strobe_n),
    .data_strobe_oe_n(host_bus.data_strobe_oe_n),
    .bus_select_straps(host_bus.bus_select_straps));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    if (done === 1'b1) done_cnt++;
    if (aborted === 1'b1) abort_cnt++;
    if (slave_start === 1'b1) slave_cnt++;
    if (mcycle === 1'b1) mcyc_cnt++;
    if (host_bus.dev_start_oe_n === 1'b0 && host_bus.dev_start_n_o === 1'b0)
      pin_addr = host_bus.dev_addr_o;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input word_t seen, input word_t exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reset_dut(input logic [2:0] m);
    i_rst = 1'b1;
    straps = m;
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (6) @(negedge i_clock);
  endtask
  task automatic go(input logic w, input word_t a, input word_t d, input lanes_t l);
    @(negedge i_clock);
    wr = w;
    addr = a;
    wdata = d;
    lanes = l;
    req = 1'b1;
    @(negedge i_clock);
    req = 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge i_clock);
    while (busy !== 1'b0 && n < 60)
    begin
      @(negedge i_clock);
      n++;
    end
    check({31'h0, busy}, 32'h0000_0000);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_rst = 1'b1;
    {ctrl, req, wr, abort, sreq, straps} = '0;
    {addr, wdata, saddr, rdata_in, lanes} = '0;
    for (int m = 0; m < 4; m++)
    begin
      reset_dut(m[2:0]);
      go(1'b1, 32'h1234_5670 + m, 32'hA5C3_0F81 ^ m, 4'h6);
      wait_idle();
      check(pin_addr, {addr[31:2], (m == 3) ? ~lanes[1:0] : addr[1:0]});
      check(mwdata, wdata);
      check(maddr, {addr[31:2], (m == 3) ? ~lanes[1:0] : addr[1:0]});
      check({31'h0, hperr}, 32'h0000_0000);
      rdata_in = 32'h7E18_C3B5 + m;
      go(1'b0, 32'h0BAD_F00C, 32'h0000_0000, 4'hF);
      wait_idle();
      check(rdata, rdata_in);
      check({31'h0, dperr}, 32'h0000_0000);
      check(done_cnt, 2);
      check(mcyc_cnt, 2);
      @(negedge i_clock);
      saddr = 32'h4000_0040 + 32'h10 * m;
      sreq = 1'b1;
      @(negedge i_clock);
      sreq = 1'b0;
      repeat (20) @(negedge i_clock);
      check(slave_cnt, 1);
      check({slave_addr[31:2], 2'h0}, saddr);
      done_cnt = 0;
      mcyc_cnt = 0;
      slave_cnt = 0;
      $display("mode test %0d ended", m + 1);
    end
    reset_dut(3'h0);
    ctrl = 8'h04;
    repeat (2) @(negedge i_clock);
    go(1'b1, 32'h2000_0000, 32'hFFFF_0001, 4'hF);
    wait_idle();
    check(mwdata, wdata);
    go(1'b1, 32'h2000_0004, 32'h1357_9BDF, 4'hF);
    abort = 1'b1;
    wait_idle();
    repeat (3) @(negedge i_clock);
    check(abort_cnt, 1);
    check({31'h0, released}, 32'h0000_0001);
    go(1'b1, 32'h2000_0008, 32'h0000_1111, 4'hF);
    repeat (3) @(negedge i_clock);
    check({31'h0, busy}, 32'h0000_0000);
    abort = 1'b0;
    repeat (4) @(negedge i_clock);
    go(1'b1, 32'h2000_000C, 32'h2468_ACE0, 4'hF);
    wait_idle();
    check(mwdata, wdata);
    $display("abort test ended");
    report_and_stop();
  end
  initial
  begin
    #100us;
    err_count++;
    report_and_stop();
  end
endmodule
